// [hw/fmc_map.svh]
/*
  Register offsets, field positions, reset values and decode figures
  of the fan monitor configuration bank.
  Assumes an 8-bit register address space reached by byte offsets.
*/
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

// Register offsets
`define FMC_OFS_PULSE_SEL   8'h7b
`define FMC_OFS_CFG5        8'h7c
`define FMC_OFS_CFG4        8'h7d

// Reset values
`define FMC_RST_PULSE_SEL   8'h55
`define FMC_RST_CFG5        8'h00
`define FMC_RST_CFG4        8'h00

// Configuration five fields
`define FMC_C5_TWOS         0
`define FMC_C5_BAND         1
`define FMC_C5_GDIR         2
`define FMC_C5_GPOL         3

// Configuration four fields
`define FMC_C4_ROLE_LO      0
`define FMC_C4_THR_LO       2
`define FMC_C4_BYPASS       5
`define FMC_C4_WMASK        8'h2f

// Sense thresholds in millivolts
`define FMC_THR_MV0         8'd20
`define FMC_THR_MV1         8'd40
`define FMC_THR_MV2         8'd80
`define FMC_THR_MV3         8'd130

// Offset of the offset-64 temperature format
`define FMC_TEMP_OFFSET     10'sd64

`endif

// [hw/fmc_pkg.sv]
/*
  Types of the fan monitor configuration bank.
  Assumes fmc_map.svh is on the include path.
*/
package fmc_pkg;

  // Roles of the multi-function pin
  typedef enum logic [1:0] {
    FMC_ROLE_TACH,
    FMC_ROLE_THERMAL,
    FMC_ROLE_ALERT,
    FMC_ROLE_GENERAL
  } fmc_role_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fmc_req_t;

  // Register port answer
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } fmc_rsp_t;

  // Drive of the multi-function pin
  typedef struct packed {
    logic out;
    logic oe;
  } fmc_pin_t;

  // Settings presented to the measurement logic
  typedef struct packed {
    logic [3:0][2:0] pulses;
    logic            twos_compl;
    logic            drive_frequency_band;
    logic            fourth_speed_sense_input;
    logic            thermal_monitor_en;
    logic            alert_on_pin;
    logic [7:0]      two_wire_sense_threshold;
    logic            supply_attenuator_bypass;
  } fmc_cfg_t;

endpackage : fmc_pkg

// [hw/fmc_config_regs.sv]
/*
  Configuration bank of a thermal monitor and fan controller: pulse
  count select, configuration five and configuration four, with decode
  of their settings, multi-function pin drive and format-aware
  temperature interpretation.
  The pulse count select register is never frozen; configuration four
  and five ignore writes while the lock level is high.
  Every setting handed to the measurement logic is decoded from the
  value being stored, so it changes on the same edge as the register.
  The multi-function pin is driven open drain in its thermal and alert
  roles and push-pull as a general output.
  Temperatures are reconverted whenever the format bit changes, so
  limits and readings always compare in one format.
  Assumes a synchronous register port with read data one cycle after
  the read strobe, a lock level from elsewhere, and synchronous pins.
  Assumes the thermal enable bit and the assert requests come from
  registered logic of the same clock.
  Assumes temperature and limit codes are stable for a cycle before
  the conversion is used.
*/
// What this block does
// - Two-bit code counts one to four pulses
// - Four fan fields, reset value 0x55
// - Config five bit0 picks temperature format
// - Temperatures follow the newly selected format
// - Config five bit1 picks drive frequency band
// - Bit2 sets general pin direction
// - Bit3 sets general pin output polarity
// - Config four bits1:0 pick pin role
// - Bits3:2 pick two-wire tach threshold
// - Bit5 bypasses supply channel attenuator
// - Lock freezes config four and five
// - Config registers reset to 0x00
// - Thermal monitoring needs enable and role
`timescale 1ns/1ps
`include "fmc_map.svh"

module fmc_config_regs
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire fmc_req_t         req,
  output fmc_rsp_t              rsp,
  input  wire logic             global_lock,
  input  wire logic             thermal_enable_cfg,
  input  wire logic             thermal_assert_req,
  input  wire logic             alert_assert_req,
  input  wire logic             general_pin_assert,
  input  wire logic             pin_in,
  output fmc_pin_t              pin,
  output logic                  general_pin_level,
  output fmc_cfg_t              cfg,
  input  wire logic [7:0]       temp_code,
  input  wire logic [7:0]       limit_code,
  output logic signed [9:0]     temp_celsius,
  output logic                  temp_over_limit
);

  ////////////////////////////////////////////////////////////////////
  // Elaboration check

  // Address width must match the byte offsets
  if (ADDR_W != 8)
  begin : g_bad_addr
    $error("fmc_config_regs serves only an 8-bit register address");
  end

  // Field positions must stay inside an 8-bit register
  if (`FMC_C5_GPOL > 7 || `FMC_C4_BYPASS > 7 || `FMC_C4_THR_LO > 6)
  begin : g_bad_field
    $error("fmc_config_regs has a field outside its register");
  end

  // Unused bits of configuration four must never be writable
  if ((`FMC_C4_WMASK & 8'hd0) != 8'h00)
  begin : g_bad_mask
    $error("fmc_config_regs lets unused bits be written");
  end

  // The three offsets must select distinct registers
  if (`FMC_OFS_PULSE_SEL == `FMC_OFS_CFG5 || `FMC_OFS_CFG5 == `FMC_OFS_CFG4 ||
      `FMC_OFS_PULSE_SEL == `FMC_OFS_CFG4)
  begin : g_bad_ofs
    $error("fmc_config_regs has overlapping register offsets");
  end

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Pulses counted for a two-bit code
  function automatic logic [2:0] pulses_of(input logic [1:0] code);
    pulses_of = {1'b0, code} + 3'd1;
  endfunction : pulses_of

  // Temperature code to degrees in the selected format
  function automatic logic signed [9:0] to_celsius(
    input logic [7:0] code,
    input logic       twos
  );
    if (twos)
    begin
      to_celsius = {{2{code[7]}}, code};
    end
    else
    begin
      to_celsius = $signed({2'b00, code}) - `FMC_TEMP_OFFSET;
    end
  endfunction : to_celsius

  // Threshold in millivolts for a two-bit code
  function automatic logic [7:0] threshold_mv(input logic [1:0] code);
    unique case (code)
      2'b00:   threshold_mv = `FMC_THR_MV0;
      2'b01:   threshold_mv = `FMC_THR_MV1;
      2'b10:   threshold_mv = `FMC_THR_MV2;
      2'b11:   threshold_mv = `FMC_THR_MV3;
    endcase
  endfunction : threshold_mv

  // One-hot select of the register at an offset, zero if unmapped
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    unique case (addr)
      `FMC_OFS_PULSE_SEL: reg_select = 3'b001;
      `FMC_OFS_CFG5:      reg_select = 3'b010;
      `FMC_OFS_CFG4:      reg_select = 3'b100;
      default:            reg_select = 3'b000;
    endcase
  endfunction : reg_select

  ////////////////////////////////////////////////////////////////////
  // State

  // Everything the block keeps, registered as one word
  typedef struct packed {
    logic [7:0]        pulse_sel;
    logic [7:0]        cfg5;
    logic [7:0]        cfg4;
    fmc_rsp_t          rsp;
    fmc_pin_t          pin;
    logic              general_pin_level;
    fmc_cfg_t          cfg;
    logic signed [9:0] temp_celsius;
    logic              temp_over_limit;
  } fmc_state_t;

  // Present and next value of the whole state
  fmc_state_t state;
  fmc_state_t next_state;

  // Register contents being stored, seen by the decode
  logic [7:0]        pulse_sel_now;
  logic [7:0]        cfg5_now;
  logic [7:0]        cfg4_now;
  fmc_role_t         role;
  logic signed [9:0] limit_celsius;
  logic signed [9:0] reading_celsius;

  // One-hot register select of the write and the read strobe
  logic [2:0]        wr_sel;
  logic [2:0]        rd_sel;

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Register writes, read answer and setting decode
  always_comb
  begin
    next_state = state;

    // Register selected by each strobe, none for unmapped offsets
    wr_sel = req.wr ? reg_select(req.addr) : 3'b000;
    rd_sel = req.rd ? reg_select(req.addr) : 3'b000;

    // Pulse count select is never frozen by the lock
    if (wr_sel[0])
    begin
      next_state.pulse_sel = req.wdata;
    end

    // Configuration five ignores writes while locked
    if (wr_sel[1] && !global_lock)
    begin
      next_state.cfg5 = req.wdata;
    end

    // Configuration four ignores writes while locked, unused bits stay zero
    if (wr_sel[2] && !global_lock)
    begin
      next_state.cfg4 = req.wdata & `FMC_C4_WMASK;
    end

    // Read data in the cycle after the strobe only, zero otherwise
    next_state.rsp.rvalid = req.rd;
    next_state.rsp.rdata  = 8'h00;
    if (rd_sel[0])
    begin
      next_state.rsp.rdata = state.pulse_sel;
    end
    if (rd_sel[1])
    begin
      next_state.rsp.rdata = state.cfg5;
    end
    if (rd_sel[2])
    begin
      next_state.rsp.rdata = state.cfg4;
    end

    // Settings decoded from the values being stored, same edge
    pulse_sel_now = next_state.pulse_sel;
    cfg5_now      = next_state.cfg5;
    cfg4_now      = next_state.cfg4;
    role          = fmc_role_t'(cfg4_now[`FMC_C4_ROLE_LO +: 2]);

    // Pulse counts per fan channel
    for (int i = 0; i < 4; i++)
    begin
      next_state.cfg.pulses[i] = pulses_of(pulse_sel_now[2*i +: 2]);
    end

    // Format and drive band straight from configuration five
    next_state.cfg.twos_compl = cfg5_now[`FMC_C5_TWOS];
    next_state.cfg.drive_frequency_band = cfg5_now[`FMC_C5_BAND];

    // Pin role flags
    next_state.cfg.fourth_speed_sense_input = (role == FMC_ROLE_TACH);
    next_state.cfg.alert_on_pin = (role == FMC_ROLE_ALERT);

    // Thermal monitoring needs both its enable and the thermal role
    next_state.cfg.thermal_monitor_en =
      thermal_enable_cfg && (role == FMC_ROLE_THERMAL);

    // Threshold applies in low-frequency drive only
    next_state.cfg.two_wire_sense_threshold =
      cfg5_now[`FMC_C5_BAND] ? threshold_mv(cfg4_now[`FMC_C4_THR_LO +: 2])
                             : 8'h00;

    // Supply channel attenuator bypass
    next_state.cfg.supply_attenuator_bypass = cfg4_now[`FMC_C4_BYPASS];

    // Multi-function pin drive, open drain for thermal and alert
    next_state.pin.out = 1'b0;
    next_state.pin.oe  = 1'b0;
    unique case (role)
      // Fourth tach input, never driven
      FMC_ROLE_TACH:
      begin
        next_state.pin.oe = 1'b0;
      end
      // Thermal output pulls low on request
      FMC_ROLE_THERMAL:
      begin
        next_state.pin.oe = thermal_assert_req;
      end
      // Alert output pulls low on request
      FMC_ROLE_ALERT:
      begin
        next_state.pin.oe = alert_assert_req;
      end
      // General pin, driven only as an output
      FMC_ROLE_GENERAL:
      begin
        if (cfg5_now[`FMC_C5_GDIR])
        begin
          next_state.pin.oe  = 1'b1;
          next_state.pin.out =
            cfg5_now[`FMC_C5_GPOL] ? general_pin_assert
                                   : !general_pin_assert;
        end
      end
    endcase

    // Input level of the general pin, zero unless it is an input
    next_state.general_pin_level =
      (role == FMC_ROLE_GENERAL) && !cfg5_now[`FMC_C5_GDIR] && pin_in;

    // Reading and limit both in the format now selected
    reading_celsius = to_celsius(temp_code, cfg5_now[`FMC_C5_TWOS]);
    limit_celsius   = to_celsius(limit_code, cfg5_now[`FMC_C5_TWOS]);

    // Converted reading and its comparison against the limit
    next_state.temp_celsius    = reading_celsius;
    next_state.temp_over_limit = reading_celsius > limit_celsius;
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // Reset values match the decode of the reset contents
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Stored registers
      state.pulse_sel  <= `FMC_RST_PULSE_SEL;
      state.cfg5       <= `FMC_RST_CFG5;
      state.cfg4       <= `FMC_RST_CFG4;

      // Port answer and pin drive
      state.rsp        <= '0;
      state.pin        <= '0;
      state.general_pin_level <= 1'b0;

      // Settings decoded from the reset contents
      state.cfg.pulses <= {4{3'd2}};
      state.cfg.twos_compl <= 1'b0;
      state.cfg.drive_frequency_band <= 1'b0;
      state.cfg.fourth_speed_sense_input <= 1'b1;
      state.cfg.thermal_monitor_en <= 1'b0;
      state.cfg.alert_on_pin <= 1'b0;
      state.cfg.two_wire_sense_threshold <= 8'h00;
      state.cfg.supply_attenuator_bypass <= 1'b0;

      // Temperature outputs
      state.temp_celsius    <= '0;
      state.temp_over_limit <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  // Register port answer
  assign rsp               = state.rsp;

  // Pin drive and sensed level
  assign pin               = state.pin;
  assign general_pin_level = state.general_pin_level;

  // Settings for the measurement logic
  assign cfg               = state.cfg;

  // Converted temperature and limit flag
  assign temp_celsius      = state.temp_celsius;
  assign temp_over_limit   = state.temp_over_limit;

endmodule : fmc_config_regs

// [verification/fmc_properties.sv]
/*
  Port assertions of the fan monitor configuration bank.
  Assumes it is bound to fmc_config_regs and sees only its ports.
*/
`timescale 1ns/1ps
module fmc_properties
  import fmc_pkg::*;
(
  input wire logic     clock,
  input wire logic     arst_n,
  input wire fmc_req_t req,
  input wire fmc_rsp_t rsp,
  input wire logic     global_lock,
  input wire fmc_cfg_t cfg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [7:0] wd_q;
  logic       w7b;
  logic       w7c;
  logic       w7d;
  // Write data of the last cycle and decoded writes
  always_ff @(posedge clock) wd_q <= req.wdata;
  assign w7b = req.wr && req.addr == 8'h7b;
  assign w7c = req.wr && req.addr == 8'h7c;
  assign w7d = req.wr && req.addr == 8'h7d && !global_lock;
  ////////////////////////////////////////////////////////////////////////
  property p_rd_ans; req.rd |=> rsp.rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_rd_idle; !req.rd |=> !rsp.rvalid && rsp.rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_first_channel_pulse_count; w7b |=> cfg.pulses[0] == {1'b0, wd_q[1:0]} + 3'h1; endproperty
  a_first_channel_pulse_count: assert property (p_first_channel_pulse_count) else $error("fan one count wrong");
  property p_fourth_channel_pulse_count; w7b |=> cfg.pulses[3] == {1'b0, wd_q[7:6]} + 3'h1; endproperty
  a_fourth_channel_pulse_count: assert property (p_fourth_channel_pulse_count) else $error("fan four count wrong");
  property p_cfg5;
    w7c && !global_lock |=> cfg.twos_compl == wd_q[0] && cfg.drive_frequency_band == wd_q[1];
  endproperty
  a_cfg5: assert property (p_cfg5) else $error("format or band wrong");
  property p_lock;
    w7c && global_lock |=> $stable(cfg.twos_compl) && $stable(cfg.drive_frequency_band);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took");
  property p_thr_hf; !cfg.drive_frequency_band |-> cfg.two_wire_sense_threshold == 8'h00;
  endproperty
  a_thr_hf: assert property (p_thr_hf) else $error("threshold in high band");
  property p_thr;
    w7d && req.wdata[3:2] == 2'b11 && cfg.drive_frequency_band |=>
      cfg.two_wire_sense_threshold == 8'h82;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not 130");
  property p_byp;
    w7d |=> cfg.supply_attenuator_bypass == wd_q[5] &&
      cfg.fourth_speed_sense_input == (wd_q[1:0] == 2'b00);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass or role wrong");
  property p_rsv; req.rd && req.addr == 8'h7d |=> rsp.rdata[7:6] == 2'b00 && !rsp.rdata[4];
  endproperty
  a_rsv: assert property (p_rsv) else $error("unused bits not zero");
  // Main scenarios
  c_wr5: cover property (w7c && !global_lock);
  c_lock: cover property (w7c && global_lock);
  c_rd: cover property (req.rd ##1 rsp.rvalid);
endmodule : fmc_properties

// [verification/fmc_host.sv]
/*
  Host model issuing register writes and reads.
  Assumes read data stand in the cycle after the strobe.
*/
`timescale 1ns/1ps
module fmc_host
  import fmc_pkg::*;
(
  input  wire logic     clock,
  output fmc_req_t      req,
  input  wire fmc_rsp_t rsp
);
  initial req = '0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  // Read strobe, answer taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    @(posedge clock);
    d = rsp.rdata;
    v = rsp.rvalid;
  endtask : rd
endmodule : fmc_host

// [verification/tb.sv]
/*
  Self-checking bench of the configuration bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
module tb
  import fmc_pkg::*;
;
  typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } fmc_row_t;
  localparam fmc_row_t ROWS [6] = '{'{8'h7b, 8'h1b, 8'h1b}, '{8'h7b, 8'he4, 8'he4},
    '{8'h7c, 8'hf3, 8'hf3}, '{8'h7d, 8'hff, 8'h2f}, '{8'h7d, 8'h0d, 8'h0d},
    '{8'h20, 8'haa, 8'h00}};
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic              global_lock = 1'b0;
  logic              general_pin_assert = 1'b0;
  logic              pin_in = 1'b0;
  logic              thermal_enable_cfg = 1'b0;
  logic              thermal_assert_req = 1'b0;
  logic              alert_assert_req = 1'b0;
  logic [7:0]        temp_code = 8'h80;
  logic [7:0]        limit_code = 8'h7f;
  fmc_req_t          req;
  fmc_rsp_t          rsp;
  fmc_pin_t          pin;
  fmc_cfg_t          cfg;
  logic              general_pin_level;
  logic signed [9:0] temp_celsius;
  logic              temp_over_limit;
  logic [7:0]        rdv;
  logic              vld;
  int                err_count = 0;
  int                checks_done = 0;
  always #10 clock = ~clock;
  fmc_host u_fmc_host (.clock, .req, .rsp);
  fmc_config_regs #(.ADDR_W(8)) u_fmc_config_regs (.clock, .arst_n, .req, .rsp, .global_lock,
    .thermal_enable_cfg, .thermal_assert_req, .alert_assert_req, .general_pin_assert, .pin_in,
    .pin, .general_pin_level, .cfg, .temp_code, .limit_code, .temp_celsius, .temp_over_limit);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_fmc_host.rd(a, rdv, vld);
    chk({vld, rdv}, {4'h1, e});
  endtask : rdc
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    chk(cfg.pulses, 12'h492);
    chk({cfg.twos_compl, cfg.drive_frequency_band, cfg.fourth_speed_sense_input, pin.oe}, 12'h002);
    rdc(8'h7b, 8'h55);
    rdc(8'h7c, 8'h00);
    rdc(8'h7d, 8'h00);
    $display("reset test done");
    foreach (ROWS[i])
    begin
      u_fmc_host.wr(ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    chk(cfg.pulses, 12'h8d1);
    $display("table test done");
    chk({temp_over_limit, temp_celsius}, 12'h380);
    u_fmc_host.wr(8'h7c, 8'h00);
    repeat (2) @(posedge clock);
    chk({temp_over_limit, temp_celsius}, 12'h440);
    limit_code <= 8'hc1;
    repeat (2) @(posedge clock);
    chk({temp_over_limit, temp_celsius}, 12'h040);
    $display("format test done");
    global_lock <= 1'b1;
    u_fmc_host.wr(8'h7c, 8'h0f);
    rdc(8'h7c, 8'h00);
    u_fmc_host.wr(8'h7d, 8'h20);
    rdc(8'h7d, 8'h0d);
    u_fmc_host.wr(8'h7b, 8'h55);
    rdc(8'h7b, 8'h55);
    global_lock <= 1'b0;
    $display("lock test done");
    u_fmc_host.wr(8'h7d, 8'h03);
    u_fmc_host.wr(8'h7c, 8'h0c);
    general_pin_assert <= 1'b1;
    repeat (2) @(posedge clock);
    chk({pin.oe, pin.out}, 12'h003);
    u_fmc_host.wr(8'h7c, 8'h04);
    repeat (2) @(posedge clock);
    chk({pin.oe, pin.out}, 12'h002);
    u_fmc_host.wr(8'h7c, 8'h00);
    pin_in <= 1'b1;
    repeat (2) @(posedge clock);
    chk({pin.oe, general_pin_level}, 12'h001);
    $display("pin test done");
    thermal_enable_cfg <= 1'b1;
    thermal_assert_req <= 1'b1;
    alert_assert_req <= 1'b1;
    u_fmc_host.wr(8'h7d, 8'h01);
    repeat (2) @(posedge clock);
    chk({cfg.thermal_monitor_en, cfg.alert_on_pin, pin.oe, pin.out}, 12'h00a);
    thermal_enable_cfg <= 1'b0;
    thermal_assert_req <= 1'b0;
    repeat (2) @(posedge clock);
    chk({cfg.thermal_monitor_en, cfg.alert_on_pin, pin.oe, pin.out}, 12'h000);
    thermal_enable_cfg <= 1'b1;
    u_fmc_host.wr(8'h7d, 8'h02);
    repeat (2) @(posedge clock);
    chk({cfg.thermal_monitor_en, cfg.alert_on_pin, pin.oe, pin.out}, 12'h006);
    $display("role test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rdc(8'h7d, 8'h00);
    chk({cfg.fourth_speed_sense_input, cfg.alert_on_pin}, 12'h002);
    $display("second reset test done");
    final_report();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #100us;
    err_count++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end
endmodule : tb

bind fmc_config_regs fmc_properties u_fmc_properties (.clock, .arst_n, .req, .rsp,
  .global_lock, .cfg);
